// [verilog/io_ctl_pkg.sv]
package io_ctl_pkg;
  localparam int NCHAN    = 8;
  localparam int NSUB     = 8;
  localparam int NLEVEL   = 64;
  localparam int NGREG    = 8;
  localparam int AW       = 16;
  localparam int DW       = 32;

  // Control word fields
  localparam int KW_ADDR_LSB = 0;
  localparam int KW_CNT_LSB  = 16;
  localparam int KW_CNT_W    = 14;
  localparam int KW_MODE_LSB = 30;

  // Termination word fields
  localparam int TW_NORM_LSB  = 0;
  localparam int TW_ABN_LSB   = 8;
  localparam int TW_ID_LSB    = 16;
  localparam int TW_CAUSE_LSB = 24;

  // Instruction fields for the operand address unit
  localparam int IN_DISP_LSB = 0;
  localparam int IN_IDX_LSB  = 27;
  localparam int IN_MODE_LSB = 30;
  localparam logic [1:0] AMODE_INDEXED = 2'h2;

  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_COUNT = 2'h1;
  localparam logic [1:0] MODE_IN    = 2'h2;
  localparam logic [1:0] MODE_OUT   = 2'h3;

  localparam logic [1:0] CAUSE_NONE   = 2'h0;
  localparam logic [1:0] CAUSE_NORMAL = 2'h1;
  localparam logic [1:0] CAUSE_ERROR  = 2'h2;
  localparam logic [1:0] CAUSE_INTR   = 2'h3;

  // Register byte offsets
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_STATUS   = 8'h04;
  localparam logic [7:0] A_MASK     = 8'h08;
  localparam logic [7:0] A_KEYBASE  = 8'h0c;
  localparam logic [7:0] A_TERMBASE = 8'h10;
  localparam logic [7:0] A_PAREN_LO = 8'h14;
  localparam logic [7:0] A_PAREN_HI = 8'h18;
  localparam logic [7:0] A_PARST_LO = 8'h1c;
  localparam logic [7:0] A_PARST_HI = 8'h20;
  localparam logic [7:0] A_LAST     = 8'h24;
  localparam logic [7:0] A_GSEL     = 8'h28;
  localparam logic [7:0] A_GDATA    = 8'h2c;
  localparam logic [7:0] A_EA_INSN  = 8'h30;
  localparam logic [7:0] A_EA_RES   = 8'h34;

  localparam int CTRL_EN_BIT  = 0;
  localparam int ST_NORM_BIT  = 0;
  localparam int ST_ABN_BIT   = 1;
  localparam int LAST_BUSY_BIT = 31;

  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [1:0]  MASK_RST     = 2'h0;
  localparam logic [15:0] KEYBASE_RST  = 16'h0000;
  localparam logic [15:0] TERMBASE_RST = 16'h0040;

  typedef enum logic [3:0] {
    ST_IDLE, ST_KEY_RD, ST_DATA, ST_KEY_WR, ST_TERM_RD,
    ST_TERM_WR, ST_ACT, ST_ACK, ST_REL
  } svc_state_e;
endpackage

// [verilog/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule

// [verilog/io_control_section.sv]
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module io_control_section (
  input  wire logic                    clock,
  input  wire logic                    nrst,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  output logic                         memReq,
  output logic                         memWe,
  output logic [io_ctl_pkg::AW-1:0]    memAddr,
  output logic [31:0]                  memWdata,
  input  wire logic [31:0]             memRdata,
  input  wire logic                    memAck,
  input  wire logic [7:0]              svcReq,
  input  wire logic [23:0]             svcSub,
  input  wire logic [255:0]            devData,
  input  wire logic [7:0]              devError,
  input  wire logic [7:0]              devIntr,
  output logic [7:0]                   svcAck,
  output logic [2:0]                   ackChan,
  output logic [2:0]                   ackSub,
  output logic [31:0]                  devDataOut,
  output logic                         activateValid,
  output logic [5:0]                   activateLevel,
  output logic                         irq
);
  localparam int SW = 8 + 24 + 8 + 8 + 256;
  io_ctl_pkg::svc_state_e state;
  logic [SW-1:0]  syncIn, syncOut;
  logic [255:0]   dataS;
  logic [63:0]    parEn_reg, parStat_reg, parSet;
  logic [31:0]    key_reg, ctrl_reg, last_reg, ea_reg, rdNext;
  logic [31:0]    gregs [0:io_ctl_pkg::NLEVEL*io_ctl_pkg::NGREG-1];
  logic [23:0]    subS;
  logic [15:0]    keyAddr, keyBase_reg, termBase_reg;
  logic [13:0]    keyCnt;
  logic [8:0]     gsel_reg, eaIdx;
  logic [7:0]     reqS, errS, intS, apAddr, wrAddr;
  logic [5:0]     id;
  logic [2:0]     pick, chan_reg, sub_reg;
  logic [1:0]     keyMode, cause_reg, stat_reg, mask_reg, statSet, statClr;
  logic           anyReq, term_reg, apWr, apRd, wrPend, busy;

  assign syncIn = {devData, devIntr, devError, svcSub, svcReq};

  // Device pins arrive from other clock domains; data is held stable while requesting
  pin_sync #(.W(SW)) u_sync (
    .clock (clock),
    .nrst  (nrst),
    .din   (syncIn),
    .dout  (syncOut)
  );
  assign reqS  = syncOut[7:0];
  assign subS  = syncOut[31:8];
  assign errS  = syncOut[39:32];
  assign intS  = syncOut[47:40];
  assign dataS = syncOut[SW-1:48];
  // Lowest channel wins; the rest wait their turn
  always_comb begin
    pick   = 3'h0;
    anyReq = 1'b0;
    for (int i = io_ctl_pkg::NCHAN - 1; i >= 0; i--) begin
      if (reqS[i]) begin
        pick   = 3'(i);
        anyReq = 1'b1;
      end
    end
  end
  assign id      = {chan_reg, sub_reg};
  assign keyMode = key_reg[io_ctl_pkg::KW_MODE_LSB +: 2];
  assign keyCnt  = key_reg[io_ctl_pkg::KW_CNT_LSB +: io_ctl_pkg::KW_CNT_W];
  assign keyAddr = key_reg[io_ctl_pkg::KW_ADDR_LSB +: io_ctl_pkg::AW];
  assign busy    = (state != io_ctl_pkg::ST_IDLE);
  assign memReq = (state == io_ctl_pkg::ST_KEY_RD) || (state == io_ctl_pkg::ST_DATA) ||
                  (state == io_ctl_pkg::ST_KEY_WR) || (state == io_ctl_pkg::ST_TERM_RD) ||
                  (state == io_ctl_pkg::ST_TERM_WR);
  assign activateValid = (state == io_ctl_pkg::ST_ACT);
  assign svcAck = (state == io_ctl_pkg::ST_ACK) ? (8'h01 << chan_reg) : 8'h00;
  // Service sequencer
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state         <= io_ctl_pkg::ST_IDLE;
      chan_reg      <= 3'h0;
      sub_reg       <= 3'h0;
      key_reg       <= 32'h0000_0000;
      cause_reg     <= io_ctl_pkg::CAUSE_NONE;
      term_reg      <= 1'b0;
      memWe         <= 1'b0;
      memAddr       <= 16'h0000;
      memWdata      <= 32'h0000_0000;
      devDataOut    <= 32'h0000_0000;
      activateLevel <= 6'h00;
      ackChan       <= 3'h0;
      ackSub        <= 3'h0;
    end else begin
      case (state)
        io_ctl_pkg::ST_IDLE: begin
          if (anyReq && ctrl_reg[io_ctl_pkg::CTRL_EN_BIT]) begin
            chan_reg <= pick;
            sub_reg  <= subS[pick*3 +: 3];
            memAddr  <= keyBase_reg + {10'h000, pick, subS[pick*3 +: 3]};
            memWe    <= 1'b0;
            term_reg <= 1'b0;
            state    <= io_ctl_pkg::ST_KEY_RD;
          end
        end
        io_ctl_pkg::ST_KEY_RD: begin
          if (memAck) begin
            key_reg  <= memRdata;
            memWdata <= memRdata;
            memAddr  <= keyBase_reg + {10'h000, id};
            memWe    <= 1'b1;
            state    <= io_ctl_pkg::ST_KEY_WR;
            if (errS[chan_reg] || intS[chan_reg]) begin
              cause_reg <= intS[chan_reg] ? io_ctl_pkg::CAUSE_INTR : io_ctl_pkg::CAUSE_ERROR;
              term_reg  <= 1'b1;
            end else if (memRdata[io_ctl_pkg::KW_MODE_LSB +: 2] == io_ctl_pkg::MODE_OFF) begin
              memWe <= 1'b0;
              state <= io_ctl_pkg::ST_ACK;
            end else if (memRdata[io_ctl_pkg::KW_CNT_LSB +: io_ctl_pkg::KW_CNT_W] == 14'h0) begin
              cause_reg <= io_ctl_pkg::CAUSE_NORMAL;
              term_reg  <= 1'b1;
            end else if (memRdata[io_ctl_pkg::KW_MODE_LSB +: 2] == io_ctl_pkg::MODE_COUNT) begin
              // Clock use: no data moves, only the count runs down
              memWdata[io_ctl_pkg::KW_CNT_LSB +: io_ctl_pkg::KW_CNT_W] <=
                memRdata[io_ctl_pkg::KW_CNT_LSB +: io_ctl_pkg::KW_CNT_W] - 14'h1;
              cause_reg <= io_ctl_pkg::CAUSE_NORMAL;
              term_reg  <= (memRdata[io_ctl_pkg::KW_CNT_LSB +: io_ctl_pkg::KW_CNT_W] == 14'h1);
            end else begin
              memAddr  <= memRdata[io_ctl_pkg::KW_ADDR_LSB +: io_ctl_pkg::AW];
              memWe    <= (memRdata[io_ctl_pkg::KW_MODE_LSB +: 2] == io_ctl_pkg::MODE_IN);
              memWdata <= dataS[chan_reg*32 +: 32];
              state    <= io_ctl_pkg::ST_DATA;
            end
          end
        end
        io_ctl_pkg::ST_DATA: begin
          if (memAck) begin
            if (!memWe) begin
              devDataOut <= memRdata;
            end
            memAddr   <= keyBase_reg + {10'h000, id};
            memWe     <= 1'b1;
            memWdata  <= {keyMode, keyCnt - 14'h1, keyAddr + 16'h0001};
            cause_reg <= io_ctl_pkg::CAUSE_NORMAL;
            term_reg  <= (keyCnt == 14'h1);
            state     <= io_ctl_pkg::ST_KEY_WR;
          end
        end
        io_ctl_pkg::ST_KEY_WR: begin
          if (memAck) begin
            memWe   <= 1'b0;
            memAddr <= termBase_reg + {10'h000, id};
            state   <= term_reg ? io_ctl_pkg::ST_TERM_RD : io_ctl_pkg::ST_ACK;
          end
        end
        io_ctl_pkg::ST_TERM_RD: begin
          if (memAck) begin
            activateLevel <= (cause_reg == io_ctl_pkg::CAUSE_NORMAL) ?
                             memRdata[io_ctl_pkg::TW_NORM_LSB +: 6] :
                             memRdata[io_ctl_pkg::TW_ABN_LSB +: 6];
            memWdata <= memRdata;
            memWdata[io_ctl_pkg::TW_CAUSE_LSB +: 2] <= cause_reg;
            memWdata[io_ctl_pkg::TW_ID_LSB +: 6]    <= id;
            memWe    <= 1'b1;
            state    <= io_ctl_pkg::ST_TERM_WR;
          end
        end
        io_ctl_pkg::ST_TERM_WR: begin
          if (memAck) begin
            memWe <= 1'b0;
            state <= io_ctl_pkg::ST_ACT;
          end
        end
        io_ctl_pkg::ST_ACT: begin
          state <= io_ctl_pkg::ST_ACK;
        end
        io_ctl_pkg::ST_ACK: begin
          ackChan <= chan_reg;
          ackSub  <= sub_reg;
          state   <= io_ctl_pkg::ST_REL;
        end
        io_ctl_pkg::ST_REL: begin
          // Wait for the synchronised request to fall so it is not served twice
          if (!reqS[chan_reg]) begin
            state <= io_ctl_pkg::ST_IDLE;
          end
        end
        default: state <= io_ctl_pkg::ST_IDLE;
      endcase
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign apWr      = hsel && htrans[1] && hready && hwrite;
  assign apRd      = hsel && htrans[1] && hready && !hwrite;
  assign apAddr    = {haddr[7:2], 2'h0};
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end else begin
      wrPend <= apWr;
      wrAddr <= apAddr;
    end
  end

  always_comb begin
    rdNext = 32'h0000_0000;
    case (apAddr)
      io_ctl_pkg::A_CTRL:     rdNext = ctrl_reg;
      io_ctl_pkg::A_STATUS:   rdNext = {30'h0, stat_reg};
      io_ctl_pkg::A_MASK:     rdNext = {30'h0, mask_reg};
      io_ctl_pkg::A_KEYBASE:  rdNext = {16'h0, keyBase_reg};
      io_ctl_pkg::A_TERMBASE: rdNext = {16'h0, termBase_reg};
      io_ctl_pkg::A_PAREN_LO: rdNext = parEn_reg[31:0];
      io_ctl_pkg::A_PAREN_HI: rdNext = parEn_reg[63:32];
      io_ctl_pkg::A_PARST_LO: rdNext = parStat_reg[31:0];
      io_ctl_pkg::A_PARST_HI: rdNext = parStat_reg[63:32];
      io_ctl_pkg::A_LAST:     rdNext = {busy, last_reg[30:0]};
      io_ctl_pkg::A_GSEL:     rdNext = {23'h0, gsel_reg};
      io_ctl_pkg::A_GDATA:    rdNext = gregs[gsel_reg];
      io_ctl_pkg::A_EA_RES:   rdNext = ea_reg;
      default:                rdNext = 32'h0000_0000;
    endcase
  end

  // Read data is latched at the address phase, so a read right after a write sees the old value
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (apRd) begin
      hrdata <= rdNext;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg     <= io_ctl_pkg::CTRL_RST;
      mask_reg     <= io_ctl_pkg::MASK_RST;
      keyBase_reg  <= io_ctl_pkg::KEYBASE_RST;
      termBase_reg <= io_ctl_pkg::TERMBASE_RST;
      parEn_reg    <= 64'h0;
      gsel_reg     <= 9'h000;
    end else if (wrPend) begin
      case (wrAddr)
        io_ctl_pkg::A_CTRL:     ctrl_reg     <= hwdata;
        io_ctl_pkg::A_MASK:     mask_reg     <= hwdata[1:0];
        io_ctl_pkg::A_KEYBASE:  keyBase_reg  <= hwdata[15:0];
        io_ctl_pkg::A_TERMBASE: termBase_reg <= hwdata[15:0];
        io_ctl_pkg::A_PAREN_LO: parEn_reg[31:0]  <= hwdata;
        io_ctl_pkg::A_PAREN_HI: parEn_reg[63:32] <= hwdata;
        io_ctl_pkg::A_GSEL:     gsel_reg     <= hwdata[8:0];
        default:                ;
      endcase
    end
  end

  // Interrupt status: termination sets beat a write-one clear
  assign statSet[io_ctl_pkg::ST_NORM_BIT] = activateValid &&
                                            (cause_reg == io_ctl_pkg::CAUSE_NORMAL);
  assign statSet[io_ctl_pkg::ST_ABN_BIT]  = activateValid &&
                                            (cause_reg != io_ctl_pkg::CAUSE_NORMAL);
  assign statClr = (wrPend && wrAddr == io_ctl_pkg::A_STATUS) ? hwdata[1:0] : 2'h0;
  assign irq     = |(stat_reg & mask_reg);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stat_reg <= 2'h0;
      last_reg <= 32'h0000_0000;
    end else begin
      stat_reg <= (stat_reg & ~statClr) | statSet;
      if (activateValid) begin
        last_reg <= {6'h00, cause_reg, 2'h0, id, 10'h000, activateLevel};
      end
    end
  end

  // Level status: a termination set survives a simultaneous software write
  assign parSet = activateValid ? (64'h1 << activateLevel) : 64'h0;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      parStat_reg <= 64'h0;
    end else if (wrPend && wrAddr == io_ctl_pkg::A_PARST_LO) begin
      parStat_reg <= {parStat_reg[63:32], hwdata} | parSet;
    end else if (wrPend && wrAddr == io_ctl_pkg::A_PARST_HI) begin
      parStat_reg <= {hwdata, parStat_reg[31:0]} | parSet;
    end else begin
      parStat_reg <= parStat_reg | parSet;
    end
  end

  // Register file, no reset: it is plain storage
  always_ff @(posedge clock) begin
    if (wrPend && wrAddr == io_ctl_pkg::A_GDATA) begin
      gregs[gsel_reg] <= hwdata;
    end
  end
  // Any register, including number zero, can index
  assign eaIdx = {gsel_reg[8:3], hwdata[io_ctl_pkg::IN_IDX_LSB +: 3]};
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ea_reg <= 32'h0000_0000;
    end else if (wrPend && wrAddr == io_ctl_pkg::A_EA_INSN) begin
      if (hwdata[io_ctl_pkg::IN_MODE_LSB +: 2] >= io_ctl_pkg::AMODE_INDEXED) begin
        ea_reg <= {16'h0, hwdata[io_ctl_pkg::IN_DISP_LSB +: 16]} + gregs[eaIdx];
      end else begin
        ea_reg <= {16'h0, hwdata[io_ctl_pkg::IN_DISP_LSB +: 16]};
      end
    end
  end
  chk_key_addr: assert property (@(posedge clock) disable iff (!nrst)
    $rose(state == io_ctl_pkg::ST_KEY_RD) |->
      memAddr == keyBase_reg + {10'h000, id} && !memWe)
    else $error("control word fetch at wrong address");
  chk_one_at_time: assert property (@(posedge clock) disable iff (!nrst)
    (busy && $past(busy)) |-> $stable(chan_reg) && $stable(sub_reg))
    else $error("new service started before previous finished");
  chk_ack_addr: assert property (@(posedge clock) disable iff (!nrst)
    (|svcAck) |-> $onehot(svcAck) && svcAck[chan_reg] ##1 ackChan == $past(chan_reg))
    else $error("acknowledge address mismatch");
  chk_write_back: assert property (@(posedge clock) disable iff (!nrst)
    (state == io_ctl_pkg::ST_DATA && memAck) |=>
      state == io_ctl_pkg::ST_KEY_WR && memWe && memAddr == keyBase_reg + {10'h000, id})
    else $error("control word not written back after transfer");
  chk_count_dec: assert property (@(posedge clock) disable iff (!nrst)
    (state == io_ctl_pkg::ST_KEY_WR && keyMode == io_ctl_pkg::MODE_COUNT &&
     keyCnt != 14'h0 && cause_reg == io_ctl_pkg::CAUSE_NORMAL) |->
      memWdata[io_ctl_pkg::KW_CNT_LSB +: io_ctl_pkg::KW_CNT_W] == keyCnt - 14'h1)
    else $error("count mode did not decrement by one");
  chk_act_source: assert property (@(posedge clock) disable iff (!nrst)
    activateValid |-> $past(state) == io_ctl_pkg::ST_TERM_WR && $past(memAck))
    else $error("level activated without termination");
  chk_level_sel: assert property (@(posedge clock) disable iff (!nrst)
    activateValid |-> activateLevel == ((cause_reg == io_ctl_pkg::CAUSE_NORMAL) ?
      memWdata[io_ctl_pkg::TW_NORM_LSB +: 6] : memWdata[io_ctl_pkg::TW_ABN_LSB +: 6]))
    else $error("wrong program level selected");
  chk_cause_rec: assert property (@(posedge clock) disable iff (!nrst)
    (state == io_ctl_pkg::ST_TERM_WR) |->
      memWe && memWdata[io_ctl_pkg::TW_CAUSE_LSB +: 2] == cause_reg)
    else $error("termination cause not recorded");
  chk_par_set: assert property (@(posedge clock) disable iff (!nrst)
    activateValid |=> parStat_reg[$past(activateLevel)] && state == io_ctl_pkg::ST_ACK)
    else $error("selected level not activated");
endmodule

// [tb/io_partner_model.sv]
`timescale 1ns/1ps
module io_partner_model (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        slow,
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [15:0] memAddr,
  input  wire logic [31:0] memWdata,
  output logic      [31:0] memRdata,
  output logic             memAck,
  input  wire logic [7:0]  raise,
  input  wire logic [7:0]  svcAck,
  output logic      [7:0]  svcReq
);
  logic [31:0] mem [0:255];
  logic [2:0]  waitCnt;
  // Outside the answer cycle the data lines show the inverse, so a stale read cannot pass
  assign memRdata = memAck ? mem[memAddr[7:0]] : ~mem[memAddr[7:0]];
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      memAck  <= 1'b0;
      waitCnt <= 3'h0;
    end else begin
      memAck  <= memReq && !memAck && (waitCnt >= (slow ? 3'h4 : 3'h0));
      waitCnt <= (memReq && !memAck) ? waitCnt + 3'h1 : 3'h0;
      if (memAck && memWe) begin
        mem[memAddr[7:0]] <= memWdata;
      end
    end
  end
  // A device holds its request until acknowledged, then drops it
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      svcReq <= 8'h00;
    end else begin
      svcReq <= (svcReq | raise) & ~svcAck;
    end
  end
endmodule

// [tb/io_control_section_tb.sv]
`timescale 1ns/1ps
module io_control_section_tb;
  logic         clock, nrst, hsel, hwrite, hreadyout, hresp, memReq, memWe, memAck;
  logic         activateValid, irq, slow;
  logic [1:0]   htrans;
  logic [2:0]   hsize, ackChan, ackSub;
  logic [5:0]   activateLevel, lastLevel;
  logic [7:0]   svcReq, svcAck, devError, devIntr, raise, got;
  logic [15:0]  memAddr;
  logic [23:0]  svcSub;
  logic [31:0]  haddr, hwdata, hrdata, memWdata, memRdata, devDataOut, rd;
  logic [255:0] devData;
  int           n_fail, n_compared, nAct;

  io_control_section dut_u (.clock, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .memReq, .memWe, .memAddr, .memWdata,
    .memRdata, .memAck, .svcReq, .svcSub, .devData, .devError, .devIntr, .svcAck, .ackChan,
    .ackSub, .devDataOut, .activateValid, .activateLevel, .irq);
  io_partner_model partner_u (.clock, .nrst, .slow, .memReq, .memWe, .memAddr, .memWdata,
    .memRdata, .memAck, .raise, .svcAck, .svcReq);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (activateValid === 1'b1) begin
      nAct <= nAct + 1;
      lastLevel <= activateLevel;
    end
  end

  function automatic logic [31:0] kw(logic [1:0] m, logic [13:0] c, logic [15:0] a);
    return {m, c, a};
  endfunction

  function automatic logic [31:0] tw(logic [1:0] c, logic [5:0] id, logic [5:0] ab,
                                     logic [5:0] nl);
    return {6'h0, c, 2'h0, id, 2'h0, ab, 2'h0, nl};
  endfunction

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 100);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 100);
    rd = hrdata;
    if (k >= 100) begin
      n_fail++;
      complete_run;
    end
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register read", e, rd);
  endtask

  task automatic waitAck(input logic [7:0] m);
    int k;
    k = 0;
    do begin @(posedge clock); #1; k++; end while ((svcAck & m) == 8'h0 && k < 300);
    got = svcAck & m;
    if (k >= 300) begin
      n_fail++;
      complete_run;
    end
  endtask

  task automatic svc(input int c, input logic [2:0] s, input logic [31:0] d, input logic e,
                     input logic i);
    repeat (4) @(posedge clock);
    svcSub[3*c +: 3] <= s;
    devData[32*c +: 32] <= d;
    devError[c] <= e;
    devIntr[c] <= i;
    raise[c] <= 1'b1;
    @(posedge clock);
    raise <= 8'h0;
    waitAck(8'h1 << c);
    @(posedge clock);
    devError[c] <= 1'b0;
    devIntr[c] <= 1'b0;
    #1;
    chk("ackChan", 32'(c), {29'h0, ackChan});
    chk("ackSub", {29'h0, s}, {29'h0, ackSub});
  endtask

  initial begin
    nrst = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = 32'h0; slow = 1'b0; raise = 8'h0; svcSub = 24'h0; devData = 256'h0;
    devError = 8'h0; devIntr = 8'h0; n_fail = 0; n_compared = 0; nAct = 0;
    for (int i = 0; i < 256; i++) partner_u.mem[i] = 32'h0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    rreg(io_ctl_pkg::A_CTRL, 32'h0);
    rreg(io_ctl_pkg::A_TERMBASE, 32'h40);
    rreg(io_ctl_pkg::A_MASK, 32'h0);
    rreg(8'h3c, 32'h0);
    bus(1'b1, io_ctl_pkg::A_MASK, 32'h3);
    bus(1'b1, io_ctl_pkg::A_CTRL, 32'h1);
    // Input word on channel 2, subchannel 5, ends on count zero
    partner_u.mem[21] = kw(io_ctl_pkg::MODE_IN, 14'h1, 16'h0080);
    partner_u.mem[85] = tw(2'h0, 6'h0, 6'd9, 6'd5);
    svc(2, 3'h5, 32'h1234abcd, 1'b0, 1'b0);
    chk("data", 32'h1234abcd, partner_u.mem[128]);
    chk("key", kw(io_ctl_pkg::MODE_IN, 14'h0, 16'h0081), partner_u.mem[21]);
    chk("term", tw(io_ctl_pkg::CAUSE_NORMAL, 6'd21, 6'd9, 6'd5), partner_u.mem[85]);
    chk("level", 32'd5, {26'h0, lastLevel});
    rreg(io_ctl_pkg::A_PARST_LO, 32'h20);
    chk("irq", 32'h1, {31'h0, irq});
    bus(1'b1, io_ctl_pkg::A_STATUS, 32'h1);
    #1;
    chk("irq", 32'h0, {31'h0, irq});
    // Count mode, no data moved, second request terminates
    partner_u.mem[56] = kw(io_ctl_pkg::MODE_COUNT, 14'h2, 16'h0090);
    partner_u.mem[144] = 32'h5a5a0000;
    partner_u.mem[120] = tw(2'h0, 6'h0, 6'd11, 6'd40);
    svc(7, 3'h0, 32'hffffffff, 1'b0, 1'b0);
    chk("key", kw(io_ctl_pkg::MODE_COUNT, 14'h1, 16'h0090), partner_u.mem[56]);
    chk("activations", 32'd1, 32'(nAct));
    svc(7, 3'h0, 32'hffffffff, 1'b0, 1'b0);
    chk("untouched", 32'h5a5a0000, partner_u.mem[144]);
    chk("term", tw(io_ctl_pkg::CAUSE_NORMAL, 6'd56, 6'd11, 6'd40), partner_u.mem[120]);
    chk("level", 32'd40, {26'h0, lastLevel});
    rreg(io_ctl_pkg::A_PARST_HI, 32'h100);
    // Output word with a slow memory, no termination yet
    slow <= 1'b1;
    partner_u.mem[1] = kw(io_ctl_pkg::MODE_OUT, 14'h3, 16'h00a0);
    partner_u.mem[160] = 32'hcafef00d;
    svc(0, 3'h1, 32'h0, 1'b0, 1'b0);
    chk("devDataOut", 32'hcafef00d, devDataOut);
    chk("key", kw(io_ctl_pkg::MODE_OUT, 14'h2, 16'h00a1), partner_u.mem[1]);
    chk("activations", 32'd2, 32'(nAct));
    // Device error, then deliberate interrupt: abnormal level, word unchanged
    for (int j = 0; j < 2; j++) begin
      partner_u.mem[8 + j] = kw(io_ctl_pkg::MODE_OUT, 14'h5, 16'h00b0);
      partner_u.mem[72 + j] = tw(2'h0, 6'h0, 6'd12, 6'd7);
      svc(1, 3'(j), 32'h0, j == 0, j == 1);
      chk("key", kw(io_ctl_pkg::MODE_OUT, 14'h5, 16'h00b0), partner_u.mem[8 + j]);
      chk("term", tw(j ? 2'h3 : 2'h2, 6'(8 + j), 6'd12, 6'd7), partner_u.mem[72 + j]);
      chk("level", 32'd12, {26'h0, lastLevel});
    end
    slow <= 1'b0;
    rreg(io_ctl_pkg::A_STATUS, 32'h3);
    bus(1'b1, io_ctl_pkg::A_STATUS, 32'h1);
    bus(1'b1, io_ctl_pkg::A_MASK, 32'h1);
    #1;
    chk("irq masked", 32'h0, {31'h0, irq});
    // Two requests at once are served one after the other, lowest first
    partner_u.mem[26] = kw(io_ctl_pkg::MODE_COUNT, 14'h5, 16'h0);
    partner_u.mem[38] = kw(io_ctl_pkg::MODE_COUNT, 14'h5, 16'h0);
    @(posedge clock);
    svcSub[11:9] <= 3'h2;
    svcSub[14:12] <= 3'h6;
    raise <= 8'h18;
    @(posedge clock);
    raise <= 8'h0;
    waitAck(8'h18);
    chk("first ack", 32'h08, {24'h0, got});
    @(posedge clock);
    waitAck(8'h10);
    chk("second ack", 32'h10, {24'h0, got});
    chk("key", kw(io_ctl_pkg::MODE_COUNT, 14'h4, 16'h0), partner_u.mem[38]);
    // Mode off is only acknowledged; a zero count ends normally with no data moved
    partner_u.mem[2] = kw(io_ctl_pkg::MODE_OFF, 14'h3, 16'h00c0);
    partner_u.mem[3] = kw(io_ctl_pkg::MODE_IN, 14'h0, 16'h00c0);
    partner_u.mem[67] = tw(2'h0, 6'h0, 6'd12, 6'd33);
    svc(0, 3'h2, 32'h77, 1'b0, 1'b0);
    chk("activations", 32'd4, 32'(nAct));
    svc(0, 3'h3, 32'h77, 1'b0, 1'b0);
    chk("data", 32'h0, partner_u.mem[192]);
    chk("term", tw(io_ctl_pkg::CAUSE_NORMAL, 6'd3, 6'd12, 6'd33), partner_u.mem[67]);
    chk("level", 32'd33, {26'h0, lastLevel});
    chk("irq", 32'h1, {31'h0, irq});
    // Level 63 registers as index, register 0 included
    bus(1'b1, io_ctl_pkg::A_GSEL, 32'h1ff);
    bus(1'b1, io_ctl_pkg::A_GDATA, 32'h100);
    rreg(io_ctl_pkg::A_GDATA, 32'h100);
    bus(1'b1, io_ctl_pkg::A_GSEL, 32'h1f8);
    bus(1'b1, io_ctl_pkg::A_GDATA, 32'h10);
    bus(1'b1, io_ctl_pkg::A_EA_INSN, 32'hb8000020);
    @(posedge clock);
    rreg(io_ctl_pkg::A_EA_RES, 32'h120);
    bus(1'b1, io_ctl_pkg::A_EA_INSN, 32'h80000005);
    @(posedge clock);
    rreg(io_ctl_pkg::A_EA_RES, 32'h15);
    bus(1'b1, io_ctl_pkg::A_EA_INSN, 32'h38000020);
    @(posedge clock);
    rreg(io_ctl_pkg::A_EA_RES, 32'h20);
    complete_run;
  end
endmodule
